// [rtl/atp_pkg.sv]
/*
 Package for the axis trajectory profiler: register map, field layouts,
 reset values, timing constants and shared types.
 Assumes a 25 MHz system clock and an AXI4-Lite register bus.
*/
package atp_pkg;

  localparam int unsigned CLK_HZ = 25000000;
  localparam int unsigned SAMPLE_PERIOD_US = 1000;
  localparam int unsigned SAMPLE_CYCLES = (CLK_HZ / 1000000) * SAMPLE_PERIOD_US;

  localparam int unsigned NUM_AXES = 4;
  localparam int unsigned AXIS_STRIDE = 64;

  // Per-axis register word offsets within an axis window
  localparam logic [7:0] REG_ABS_TARGET = 8'h00;
  localparam logic [7:0] REG_REL_DISTANCE = 8'h04;
  localparam logic [7:0] REG_SLEW_VELOCITY = 8'h08;
  localparam logic [7:0] REG_RAMP_UP_RATE = 8'h0c;
  localparam logic [7:0] REG_RAMP_DOWN_RATE = 8'h10;
  localparam logic [7:0] REG_JOG_SPEED = 8'h14;
  localparam logic [7:0] REG_SMOOTHING = 8'h18;
  localparam logic [7:0] REG_MODE = 8'h1c;
  localparam logic [7:0] REG_INC_SHIFT = 8'h20;
  localparam logic [7:0] REG_CMD_POS = 8'h24;
  localparam logic [7:0] REG_STATUS = 8'h28;
  localparam logic [7:0] REG_ACT_VEL = 8'h2c;
  localparam logic [7:0] REG_IN_POS_BAND = 8'h30;
  // Global command register, beyond the axis windows
  localparam logic [7:0] REG_COMMAND = 8'hf0;

  // Command register fields
  localparam int unsigned CMD_GO_BIT = 8;
  localparam int unsigned CMD_HALT_BIT = 9;

  // Status fields
  localparam int unsigned ST_DONE_BIT = 0;
  localparam int unsigned ST_INPOS_BIT = 1;
  localparam int unsigned ST_MOVING_BIT = 2;

  localparam logic [31:0] RST_SLEW = 32'h0000_1000;
  localparam logic [31:0] RST_RAMP = 32'h0000_0100;
  localparam logic [31:0] RST_BAND = 32'h0000_0004;
  localparam logic [3:0] RST_SMOOTH = 4'h0;

  typedef enum logic [1:0] {
    ATP_IDLE = 2'b00,
    ATP_MOVE = 2'b01,
    ATP_HALT = 2'b10
  } atp_state_e;

  typedef struct packed {
    logic signed [31:0] abs_target;
    logic signed [31:0] rel_distance;
    logic [31:0] slew_velocity;
    logic [31:0] ramp_up_rate;
    logic [31:0] ramp_down_rate;
    logic signed [31:0] jog_speed;
    logic [3:0] smoothing;
    logic jog_mode;
    logic [31:0] in_pos_band;
  } atp_axis_cfg_s;

endpackage

// [rtl/atp_profiler.sv]
/*
 Multi-axis trajectory profiler with AXI4-Lite register slave.
 Positioning and jog modes, one new command position per sample tick; a jog mode shift applies its offset at once.
 Assumes measured positions arrive synchronous to sys_clk.
*/
// Design decisions made here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
module atp_profiler #(
  parameter int unsigned NUM_AXES = atp_pkg::NUM_AXES,
  parameter int unsigned SAMPLE_CYCLES = atp_pkg::SAMPLE_CYCLES
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // AXI4-Lite write address and data
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Axis position loop
  input wire logic [NUM_AXES*32-1:0] actual_position,
  output logic [NUM_AXES*32-1:0] command_position,
  output logic [NUM_AXES-1:0] profile_done_wait,
  output logic [NUM_AXES-1:0] in_position_wait,
  output logic sample_tick
);

  atp_pkg::atp_axis_cfg_s cfg [NUM_AXES];
  atp_pkg::atp_state_e state [NUM_AXES];
  logic signed [31:0] pos [NUM_AXES];
  logic signed [31:0] vel [NUM_AXES];
  logic signed [31:0] smooth_vel [NUM_AXES];
  logic signed [31:0] last_act [NUM_AXES];
  logic signed [31:0] act_vel [NUM_AXES];
  logic [31:0] tick_cnt;

  ////////////////////////////////////////////////////////////////////////
  // Common sample timebase

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      tick_cnt <= 32'h0000_0000;
      sample_tick <= 1'b0;
    end else if (tick_cnt == SAMPLE_CYCLES - 1) begin
      tick_cnt <= 32'h0000_0000;
      sample_tick <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
      sample_tick <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave, one write and one read at a time

  logic aw_held, w_held;
  logic [11:0] aw_addr;
  logic [31:0] w_data;
  logic wr_fire;
  logic [1:0] ax_w;
  logic [7:0] off_w;
  logic wr_axis_ok, wr_cmd, wr_ok;

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign ax_w = aw_addr[7:6];
  assign off_w = {2'b00, aw_addr[5:0]};
  assign wr_axis_ok = (aw_addr[11:8] == 4'h0) && (32'(ax_w) < NUM_AXES);
  assign wr_cmd = (aw_addr[11:0] == {4'h1, atp_pkg::REG_COMMAND});
  assign wr_ok = wr_cmd || (wr_axis_ok && off_w <= atp_pkg::REG_IN_POS_BAND);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0000_0000;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Decoded one-cycle write events
  logic [NUM_AXES-1:0] go_sel, halt_sel, shift_sel;
  logic [7:0] cmd_mask;
  assign cmd_mask = w_data[7:0];

  always_comb begin
    for (int i = 0; i < NUM_AXES; i++) begin
      go_sel[i] = wr_fire && wr_cmd && w_data[atp_pkg::CMD_GO_BIT] &&
                  (cmd_mask == 8'h00 || cmd_mask[i]);
      halt_sel[i] = wr_fire && wr_cmd && w_data[atp_pkg::CMD_HALT_BIT] &&
                    (cmd_mask == 8'h00 || cmd_mask[i]);
      shift_sel[i] = wr_fire && wr_axis_ok && 32'(ax_w) == i &&
                     off_w == atp_pkg::REG_INC_SHIFT;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Per-axis configuration and profile engine

  genvar g;
  generate
    for (g = 0; g < NUM_AXES; g++) begin : gen_axis
      logic wr_here;
      logic signed [31:0] remain, speed, target_v, abs_v, stop_dist, step_v;
      logic signed [31:0] delta, next_vel, next_pos;
      logic signed [63:0] brake;
      logic moving;

      assign wr_here = wr_fire && wr_axis_ok && 32'(ax_w) == g;
      assign moving = state[g] != atp_pkg::ATP_IDLE;
      // ramp-down, mode and target writes ignored while moving; a same-direction shift still moves target
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          cfg[g] <= '{abs_target: 32'h0, rel_distance: 32'h0,
                      slew_velocity: atp_pkg::RST_SLEW,
                      ramp_up_rate: atp_pkg::RST_RAMP,
                      ramp_down_rate: atp_pkg::RST_RAMP, jog_speed: 32'h0,
                      smoothing: atp_pkg::RST_SMOOTH, jog_mode: 1'b0,
                      in_pos_band: atp_pkg::RST_BAND};
        end else if (shift_sel[g] && !cfg[g].jog_mode &&
                     (!moving || (w_data[31] == vel[g][31]))) begin
          // shift at rest is relative move
          cfg[g].abs_target <= (moving ? cfg[g].abs_target : pos[g]) + w_data;
          cfg[g].rel_distance <= w_data;
        end else if (wr_here) begin
          unique case (off_w)
            atp_pkg::REG_ABS_TARGET: if (!moving) cfg[g].abs_target <= w_data;
            atp_pkg::REG_REL_DISTANCE: if (!moving) begin
              cfg[g].rel_distance <= w_data;
              cfg[g].abs_target <= cfg[g].abs_target + w_data;
            end
            atp_pkg::REG_SLEW_VELOCITY: cfg[g].slew_velocity <= w_data;
            atp_pkg::REG_RAMP_UP_RATE: cfg[g].ramp_up_rate <= w_data;
            atp_pkg::REG_RAMP_DOWN_RATE:
              if (!moving) cfg[g].ramp_down_rate <= w_data;
            atp_pkg::REG_JOG_SPEED: cfg[g].jog_speed <= w_data;
            atp_pkg::REG_SMOOTHING: cfg[g].smoothing <= w_data[3:0];
            atp_pkg::REG_MODE: if (!moving) cfg[g].jog_mode <= w_data[0];
            atp_pkg::REG_IN_POS_BAND: cfg[g].in_pos_band <= w_data;
            default: ;
          endcase
        end
      end

      // Stopping distance v*(v+dec)/(2*dec+1), compared against remaining travel
      assign remain = cfg[g].abs_target - pos[g];
      assign speed = vel[g][31] ? -vel[g] : vel[g];
      assign brake = (64'(speed) * 64'(speed + cfg[g].ramp_down_rate)) /
                     (64'(cfg[g].ramp_down_rate) * 64'd2 + 64'd1);
      assign stop_dist = brake[31:0];

      always_comb begin
        abs_v = remain[31] ? -remain : remain;
        if (state[g] == atp_pkg::ATP_HALT) begin
          target_v = 32'sd0;
        end else if (cfg[g].jog_mode) begin
          target_v = cfg[g].jog_speed;
        end else if (abs_v <= stop_dist) begin
          target_v = 32'sd0;
        end else begin
          target_v = remain[31] ? -$signed(cfg[g].slew_velocity)
                                : $signed(cfg[g].slew_velocity);
        end
        delta = target_v - vel[g];
        step_v = (speed != 0 && (target_v[31] != vel[g][31] ||
                  (target_v[31] ? target_v > vel[g] : target_v < vel[g])))
                 ? $signed(cfg[g].ramp_down_rate) : $signed(cfg[g].ramp_up_rate);
        if (delta > step_v) begin
          next_vel = vel[g] + step_v;
        end else if (delta < -step_v) begin
          next_vel = vel[g] - step_v;
        end else begin
          next_vel = target_v;
        end
        next_pos = pos[g] + smooth_vel[g];
        if (!cfg[g].jog_mode && state[g] == atp_pkg::ATP_MOVE &&
            (abs_v <= (smooth_vel[g][31] ? -smooth_vel[g] : smooth_vel[g]) ||
             (next_vel == 0 && smooth_vel[g] == 0 && abs_v <= stop_dist))) begin
          next_pos = cfg[g].abs_target;
        end
      end

      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          state[g] <= atp_pkg::ATP_IDLE;
          pos[g] <= 32'sd0;
          vel[g] <= 32'sd0;
          smooth_vel[g] <= 32'sd0;
        end else begin
          if (sample_tick && moving) begin
            pos[g] <= next_pos;
            vel[g] <= next_vel;
            smooth_vel[g] <= smooth_vel[g] +
                             ((next_vel - smooth_vel[g]) >>> cfg[g].smoothing);
            if ((!cfg[g].jog_mode && next_pos == cfg[g].abs_target &&
                 state[g] == atp_pkg::ATP_MOVE) ||
                (state[g] == atp_pkg::ATP_HALT && next_vel == 0)) begin
              state[g] <= atp_pkg::ATP_IDLE;
              vel[g] <= 32'sd0;
              smooth_vel[g] <= 32'sd0;
            end
          end
          // immediate jog offset, coincident tick not lost
          if (shift_sel[g] && cfg[g].jog_mode) begin
            pos[g] <= ((sample_tick && moving) ? next_pos : pos[g]) + w_data;
          end
          if (halt_sel[g] && moving) begin
            state[g] <= atp_pkg::ATP_HALT;
          end else if ((go_sel[g] && !moving) ||
                       (shift_sel[g] && !moving && !cfg[g].jog_mode)) begin
            state[g] <= atp_pkg::ATP_MOVE;
          end
        end
      end

      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          command_position[g*32 +: 32] <= 32'h0;
          profile_done_wait[g] <= 1'b1;
          in_position_wait[g] <= 1'b1;
          last_act[g] <= 32'sd0;
          act_vel[g] <= 32'sd0;
        end else begin
          command_position[g*32 +: 32] <= pos[g];
          profile_done_wait[g] <= !moving;
          in_position_wait[g] <= !moving &&
            ((pos[g] - $signed(actual_position[g*32 +: 32])) <=
              $signed(cfg[g].in_pos_band)) &&
            (($signed(actual_position[g*32 +: 32]) - pos[g]) <=
              $signed(cfg[g].in_pos_band));
          if (sample_tick) begin
            last_act[g] <= actual_position[g*32 +: 32];
            act_vel[g] <= $signed(actual_position[g*32 +: 32]) - last_act[g];
          end
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Read channel

  logic [1:0] ax_r;
  logic [7:0] off_r;
  logic rd_axis_ok;
  logic [31:0] rd_word;
  logic rd_hit;
  assign ax_r = s_axi_araddr[7:6];
  assign off_r = {2'b00, s_axi_araddr[5:0]};
  assign rd_axis_ok = (s_axi_araddr[11:8] == 4'h0) && (32'(ax_r) < NUM_AXES);

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = rd_axis_ok;
    if (rd_axis_ok) begin
      unique case (off_r)
        atp_pkg::REG_ABS_TARGET: rd_word = cfg[ax_r].abs_target;
        atp_pkg::REG_REL_DISTANCE: rd_word = cfg[ax_r].rel_distance;
        atp_pkg::REG_SLEW_VELOCITY: rd_word = cfg[ax_r].slew_velocity;
        atp_pkg::REG_RAMP_UP_RATE: rd_word = cfg[ax_r].ramp_up_rate;
        atp_pkg::REG_RAMP_DOWN_RATE: rd_word = cfg[ax_r].ramp_down_rate;
        atp_pkg::REG_JOG_SPEED: rd_word = cfg[ax_r].jog_speed;
        atp_pkg::REG_SMOOTHING: rd_word = {28'h0, cfg[ax_r].smoothing};
        atp_pkg::REG_MODE: rd_word = {31'h0, cfg[ax_r].jog_mode};
        atp_pkg::REG_INC_SHIFT: rd_word = 32'h0000_0000;
        atp_pkg::REG_CMD_POS: rd_word = pos[ax_r];
        atp_pkg::REG_STATUS: begin
          rd_word[atp_pkg::ST_DONE_BIT] = profile_done_wait[ax_r];
          rd_word[atp_pkg::ST_INPOS_BIT] = in_position_wait[ax_r];
          rd_word[atp_pkg::ST_MOVING_BIT] = state[ax_r] != atp_pkg::ATP_IDLE;
        end
        atp_pkg::REG_ACT_VEL: rd_word = act_vel[ax_r];
        atp_pkg::REG_IN_POS_BAND: rd_word = cfg[ax_r].in_pos_band;
        default: rd_hit = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule

// [tb/atp_axis_model.sv]
/*
 Motor axis model on the far side of the position loop.
 Assumes sample_tick is the profiler's own tick; each axis follows one tick behind.
*/
`timescale 1ns/1ps
module atp_axis_model #(
  parameter int unsigned NUM_AXES = 4
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Position loop
  input wire logic sample_tick,
  input wire logic [NUM_AXES*32-1:0] command_position,
  output logic [NUM_AXES*32-1:0] actual_position
);
  ////////////////////////////////////////////////////////////////////////////
  // lagging motor
  // One tick of lag keeps profile done and in position apart
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      actual_position <= '0;
    end else if (sample_tick) begin
      actual_position <= command_position;
    end
  end
endmodule

// [tb/atp_profiler_bench.sv]
/*
 Self-checking bench for atp_profiler: register sequences over AXI4-Lite.
 Assumes the axis model closes the loop; short sample period for speed.
*/
`timescale 1ns/1ps
module atp_profiler_bench;
  localparam int unsigned NA = 4;
  localparam int unsigned SC = 10;
  logic sys_clk;
  logic reset_n;
  logic [11:0] s_axi_awaddr;
  logic s_axi_awvalid;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic s_axi_wvalid;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready;
  logic [11:0] s_axi_araddr;
  logic s_axi_arvalid;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready;
  logic [NA*32-1:0] actual_position;
  logic [NA*32-1:0] command_position;
  logic [NA-1:0] profile_done_wait;
  logic [NA-1:0] in_position_wait;
  logic sample_tick;
  int failures;
  int samples_checked;
  logic [31:0] v;

  atp_profiler #(.NUM_AXES(NA), .SAMPLE_CYCLES(SC)) u_dut (
    .sys_clk(sys_clk), .reset_n(reset_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .actual_position(actual_position), .command_position(command_position),
    .profile_done_wait(profile_done_wait), .in_position_wait(in_position_wait),
    .sample_tick(sample_tick));
  atp_axis_model #(.NUM_AXES(NA)) u_axis (
    .sys_clk(sys_clk), .reset_n(reset_n), .sample_tick(sample_tick),
    .command_position(command_position), .actual_position(actual_position));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask
  function automatic logic [11:0] ra(input int ax, input logic [7:0] off);
    ra = 12'(ax * 64) + {4'h0, off};
  endfunction
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge sys_clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    s_axi_rready <= 1'b0;
    chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    chk("rdata", v, exp);
    @(posedge sys_clk);
  endtask
  task automatic ticks(input int n);
    repeat (n * SC) @(posedge sys_clk);
  endtask
  task automatic wait_idle(input int ax);
    repeat (3) @(posedge sys_clk);
    for (int n = 0; n < 5000 && profile_done_wait[ax] !== 1'b1; n++) @(posedge sys_clk);
    chk("done", {31'h0, profile_done_wait[ax]}, 32'h1);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (50000) @(posedge sys_clk);
    failures++;
    test_done();
  end
  initial begin
    failures = 0;
    samples_checked = 0;
    reset_n = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    for (int ax = 0; ax < NA; ax++) begin
      rd(ra(ax, atp_pkg::REG_SLEW_VELOCITY), atp_pkg::RST_SLEW, 2'b00);
      rd(ra(ax, atp_pkg::REG_RAMP_UP_RATE), atp_pkg::RST_RAMP, 2'b00);
      rd(ra(ax, atp_pkg::REG_RAMP_DOWN_RATE), atp_pkg::RST_RAMP, 2'b00);
      rd(ra(ax, atp_pkg::REG_STATUS), 32'h3, 2'b00);
    end
    // Unmapped window past the last axis
    rd(12'h100, 32'h0, 2'b10);
    wr(12'h100, 32'h1, 2'b10);
    wr(ra(0, atp_pkg::REG_SLEW_VELOCITY), 32'h8, 2'b00);
    wr(ra(0, atp_pkg::REG_RAMP_UP_RATE), 32'h1, 2'b00);
    wr(ra(0, atp_pkg::REG_RAMP_DOWN_RATE), 32'h1, 2'b00);
    rd(ra(0, atp_pkg::REG_SLEW_VELOCITY), 32'h8, 2'b00);
    // Absolute move on axis 0 only
    wr(ra(0, atp_pkg::REG_ABS_TARGET), 32'd40, 2'b00);
    wr(12'h1f0, 32'h101, 2'b00);
    wait_idle(0);
    chk("pos0", command_position[31:0], 32'd40);
    chk("pos1", command_position[63:32], 32'h0);
    ticks(2);
    chk("inpos0", {31'h0, in_position_wait[0]}, 32'h1);
    // Relative move, empty mask starts all
    wr(ra(0, atp_pkg::REG_REL_DISTANCE), 32'hffff_fff6, 2'b00);
    rd(ra(0, atp_pkg::REG_REL_DISTANCE), 32'hffff_fff6, 2'b00);
    rd(ra(0, atp_pkg::REG_ABS_TARGET), 32'd30, 2'b00);
    wr(12'h1f0, 32'h100, 2'b00);
    wait_idle(0);
    chk("pos0", command_position[31:0], 32'd30);
    // Slew raised while moving; host leaves target alone until done
    wr(ra(0, atp_pkg::REG_ABS_TARGET), 32'd130, 2'b00);
    wr(12'h1f0, 32'h101, 2'b00);
    wr(ra(0, atp_pkg::REG_SLEW_VELOCITY), 32'h10, 2'b00);
    wait_idle(0);
    chk("pos0", command_position[31:0], 32'd130);
    rd(ra(0, atp_pkg::REG_SLEW_VELOCITY), 32'h10, 2'b00);
    // Shift at rest, then shift while moving
    wr(ra(0, atp_pkg::REG_INC_SHIFT), 32'd20, 2'b00);
    wait_idle(0);
    chk("pos0", command_position[31:0], 32'd150);
    wr(ra(0, atp_pkg::REG_ABS_TARGET), 32'd250, 2'b00);
    wr(12'h1f0, 32'h101, 2'b00);
    ticks(3);
    wr(ra(0, atp_pkg::REG_INC_SHIFT), 32'd10, 2'b00);
    wait_idle(0);
    chk("pos0", command_position[31:0], 32'd260);
    // Halt in mid-move
    wr(ra(0, atp_pkg::REG_ABS_TARGET), 32'd1000, 2'b00);
    wr(12'h1f0, 32'h101, 2'b00);
    ticks(10);
    wr(12'h1f0, 32'h201, 2'b00);
    wait_idle(0);
    v = command_position[31:0];
    chk("halt", {31'h0, $signed(v) > 260 && $signed(v) < 1000}, 32'h1);
    // Smoothed short move on axis 1
    wr(ra(1, atp_pkg::REG_SMOOTHING), 32'h2, 2'b00);
    rd(ra(1, atp_pkg::REG_SMOOTHING), 32'h2, 2'b00);
    wr(ra(1, atp_pkg::REG_ABS_TARGET), 32'd20, 2'b00);
    wr(12'h1f0, 32'h102, 2'b00);
    wait_idle(1);
    chk("pos1", command_position[63:32], 32'd20);
    // Jog axis 2 in reverse, then reverse it
    wr(ra(2, atp_pkg::REG_RAMP_UP_RATE), 32'h1, 2'b00);
    wr(ra(2, atp_pkg::REG_RAMP_DOWN_RATE), 32'h1, 2'b00);
    wr(ra(2, atp_pkg::REG_MODE), 32'h1, 2'b00);
    wr(ra(2, atp_pkg::REG_JOG_SPEED), 32'hffff_fffd, 2'b00);
    wr(12'h1f0, 32'h104, 2'b00);
    ticks(20);
    chk("jog_busy", {31'h0, profile_done_wait[2]}, 32'h0);
    v = command_position[95:64];
    chk("jog_dir", {31'h0, $signed(v) < 0}, 32'h1);
    rd(ra(2, atp_pkg::REG_ACT_VEL), 32'hffff_fffd, 2'b00);
    wr(ra(2, atp_pkg::REG_JOG_SPEED), 32'h3, 2'b00);
    ticks(1);
    v = command_position[95:64];
    chk("jog_ramp", {31'h0, $signed(v) < 0}, 32'h1);
    ticks(15);
    rd(ra(2, atp_pkg::REG_ACT_VEL), 32'h3, 2'b00);
    // Offset plus at most two ticks of travel at speed 3
    v = command_position[95:64];
    wr(ra(2, atp_pkg::REG_INC_SHIFT), 32'd100, 2'b00);
    v = command_position[95:64] - v;
    chk("jog_shift", {31'h0, $signed(v) >= 100 && $signed(v) <= 106}, 32'h1);
    wr(12'h1f0, 32'h204, 2'b00);
    wait_idle(2);
    test_done();
  end
endmodule

// [tb/atp_profiler_props.sv]
/*
 Concurrent checks on the ports of atp_profiler.
 Assumes one clock domain; bound into every profiler instance.
*/
`timescale 1ns/1ps
module atp_profiler_props #(
  parameter int unsigned NUM_AXES = 4,
  parameter int unsigned SAMPLE_CYCLES = 25000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // Register bus
  input wire logic s_axi_awready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Position loop
  input wire logic [NUM_AXES*32-1:0] command_position,
  input wire logic [NUM_AXES-1:0] profile_done_wait,
  input wire logic [NUM_AXES-1:0] in_position_wait,
  input wire logic sample_tick
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  logic [31:0] cnt;
  logic seen;
  ////////////////////////////////////////////////////////////////////////////
  // Cycles since the last tick; first period after reset is unknown
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= '0;
    end else if (sample_tick) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 32'h1;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      seen <= 1'b0;
    end else if (sample_tick) begin
      seen <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  a_tick_single: assert property (sample_tick |=> !sample_tick)
    else $error("sample tick longer than one cycle");
  a_tick_period: assert property (seen |-> sample_tick == (cnt == SAMPLE_CYCLES - 1))
    else $error("sample tick period wrong");
  a_idle_still: assert property ((&profile_done_wait) && $past(&profile_done_wait)
    && !$past(s_axi_bvalid) |-> $stable(command_position))
    else $error("command position moved while all axes idle");
  a_pos_on_tick: assert property (!$past(sample_tick, 2) && !$past(s_axi_bvalid)
    |-> $stable(command_position))
    else $error("command position changed off the tick");
  a_start_after_write: assert property (|($past(profile_done_wait) & ~profile_done_wait)
    |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("profile started without a register write");
  a_done_on_tick: assert property (|(profile_done_wait & ~$past(profile_done_wait))
    |-> $past(sample_tick, 2))
    else $error("profile done rose off the tick");
  a_inpos_needs_done: assert property ((in_position_wait & ~profile_done_wait) == '0)
    else $error("in position while profiler busy");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("write address accepted with response pending");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
endmodule

bind atp_profiler atp_profiler_props #(
  .NUM_AXES(NUM_AXES),
  .SAMPLE_CYCLES(SAMPLE_CYCLES)
) u_props (
  .sys_clk(sys_clk),
  .reset_n(reset_n),
  .s_axi_awready(s_axi_awready),
  .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready),
  .command_position(command_position),
  .profile_done_wait(profile_done_wait),
  .in_position_wait(in_position_wait),
  .sample_tick(sample_tick)
);
